// ===== common/bsfu_defs.svh
// constants of the bit, shift and flag execution unit
`ifndef BSFU_DEFS_SVH
`define BSFU_DEFS_SVH

// ----------------------------------------------------------------
// status register bit positions
// ----------------------------------------------------------------
`define BSFU_FLAG_C        3'h0
`define BSFU_FLAG_Z        3'h1
`define BSFU_FLAG_N        3'h2
`define BSFU_FLAG_V        3'h3
`define BSFU_FLAG_S        3'h4
`define BSFU_FLAG_H        3'h5
`define BSFU_FLAG_T        3'h6
`define BSFU_FLAG_I        3'h7

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define BSFU_STATUS_RESET  8'h00
`define BSFU_IO_CYCLES     2
`define BSFU_ALU_CYCLES    1

`endif

// ===== common/bsfu_pkg.sv
// types of the bit, shift and flag execution unit
package bsfu_pkg;

    // ------------------------------------------------------------
    // operation codes presented by the decoder
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        io_bit_clear_op         = 5'h00,
        io_bit_set_op           = 5'h01,
        logical_left_shift_op   = 5'h02,
        logical_right_shift_op  = 5'h03,
        rotate_left_carry_op    = 5'h04,
        rotate_right_carry_op   = 5'h05,
        arith_right_shift_op    = 5'h06,
        nibble_swap_op          = 5'h07,
        flag_set_generic_op     = 5'h08,
        flag_clear_generic_op   = 5'h09,
        bit_to_transfer_flag_op = 5'h0a,
        transfer_flag_to_bit_op = 5'h0b,
        carry_set_op            = 5'h0c,
        carry_clear_op          = 5'h0d,
        irq_enable_op           = 5'h0e,
        irq_disable_op          = 5'h0f,
        signed_flag_set_op      = 5'h10,
        signed_flag_clear_op    = 5'h11,
        overflow_set_op         = 5'h12,
        overflow_clear_op       = 5'h13,
        negative_set_op         = 5'h14,
        negative_clear_op       = 5'h15,
        zero_flag_set_op        = 5'h16,
        zero_flag_clear_op      = 5'h17,
        transfer_flag_set_op    = 5'h18,
        transfer_flag_clear_op  = 5'h19
    } bsfu_op_t;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        st_idle    = 2'b01,
        st_io_read = 2'b10
    } bsfu_state_t;

endpackage

// ===== src/bsfu_bit_put.sv
// writes one bit of a word at a chosen index
`timescale 1ns/10ps
`default_nettype none

module bsfu_bit_put #(
    parameter int W = 8
) (
    // word in
    input  wire logic [W-1:0]         data_in,
    input  wire logic [$clog2(W)-1:0] index,
    input  wire logic                 value,
    // word out
    output logic      [W-1:0]         data_out
);

    always_comb begin
        data_out        = data_in;
        data_out[index] = value;
    end

endmodule // bsfu_bit_put

`default_nettype wire

// ===== src/bsfu_shifter.sv
// one-place shifts, rotates through carry and their flags
`timescale 1ns/10ps
`default_nettype none

module bsfu_shifter (
    // operand
    input  wire bsfu_pkg::bsfu_op_t op_code,
    input  wire logic [7:0]         data_in,
    input  wire logic               carry_in,
    // result and flags
    output logic      [7:0]         result,
    output logic                    carry_out,
    output logic                    zero_out,
    output logic                    negative_out,
    output logic                    overflow_out
);

    always_comb begin
        result    = data_in;
        carry_out = carry_in;
        unique case (op_code)
            bsfu_pkg::logical_left_shift_op: begin
                result    = {data_in[6:0], 1'b0};
                carry_out = data_in[7];
            end
            bsfu_pkg::logical_right_shift_op: begin
                result    = {1'b0, data_in[7:1]};
                carry_out = data_in[0];
            end
            bsfu_pkg::rotate_left_carry_op: begin
                result    = {data_in[6:0], carry_in};
                carry_out = data_in[7];
            end
            bsfu_pkg::rotate_right_carry_op: begin
                result    = {carry_in, data_in[7:1]};
                carry_out = data_in[0];
            end
            bsfu_pkg::arith_right_shift_op: begin
                // sign bit stays put
                result    = {data_in[7], data_in[7:1]};
                carry_out = data_in[0];
            end
            default: begin
                result    = data_in;
                carry_out = carry_in;
            end
        endcase
        zero_out     = (result == 8'h00);
        negative_out = result[7];
        // overflow after a shift is n xor c, which is the sign change for the left shift and left rotate only
        overflow_out = result[7] ^ carry_out;
    end

endmodule // bsfu_shifter

`default_nettype wire

// ===== src/bsfu_top.sv
// bit, shift and flag execution unit of the 8-bit core
// ----------------------------------------------------------------
// Function
// - io bit clear zeroes one bit of an io register, no flags, two cycles
// - io bit set forces one bit of an io register high, no flags, two cycles
// - logical left shift, zero into bit 0, updates z c n v, one cycle
// - logical right shift, zero into bit 7, updates z c n v, one cycle
// - rotate left through carry: old carry to bit 0, bit 7 to carry
// - rotate right through carry: old carry to bit 7, bit 0 to carry
// - arithmetic right shift keeps sign bit, updates z c n v
// - nibble swap exchanges halves, flags untouched, one cycle
// - generic flag set or clear writes the selected status bit only
// - bit store copies selected source bit into transfer flag only
// - bit load copies transfer flag into selected destination bit
// - carry set and clear write the carry flag only, one cycle
// - irq enable and disable write the interrupt enable flag only
// - signed flag set and clear write the signed flag only
// - overflow set and clear write the overflow flag only
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "bsfu_defs.svh"

module bsfu_top (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               reset,
    // instruction from the decoder
    input  wire logic               op_valid,
    input  wire bsfu_pkg::bsfu_op_t op_code,
    input  wire logic [2:0]         op_bit,
    input  wire logic [5:0]         op_io_addr,
    input  wire logic [7:0]         dst_data,
    input  wire logic [7:0]         source_register,
    output logic                    op_ready_ff,
    output logic                    done_ff,
    // working register write back
    output logic                    rf_wr_en_ff,
    output logic [7:0]              rf_wr_data_ff,
    // io space
    output logic                    io_rd_en_ff,
    output logic                    io_wr_en_ff,
    output logic [5:0]              io_addr_ff,
    output logic [7:0]              io_wr_data_ff,
    input  wire logic [7:0]         io_rd_data,
    // status
    output logic [7:0]              status_register_ff
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    bsfu_pkg::bsfu_state_t state_ff;
    logic                  accept;
    logic                  is_shift;
    logic                  io_set_ff;
    logic [2:0]            io_bit_ff;
    logic                  flag_wr;
    logic [2:0]            flag_idx;
    logic                  flag_val;
    logic [7:0]            flag_result;
    logic [7:0]            bld_result;
    logic [7:0]            io_result;
    logic [7:0]            sh_result;
    logic                  sh_c;
    logic                  sh_z;
    logic                  sh_n;
    logic                  sh_v;

    assign accept   = op_valid && op_ready_ff;
    assign is_shift = op_code inside {bsfu_pkg::logical_left_shift_op,
                                      bsfu_pkg::logical_right_shift_op,
                                      bsfu_pkg::rotate_left_carry_op,
                                      bsfu_pkg::rotate_right_carry_op,
                                      bsfu_pkg::arith_right_shift_op};

    // dedicated flag ops are folded onto the generic write of one bit
    always_comb begin
        flag_wr  = 1'b1;
        flag_idx = op_bit;
        flag_val = 1'b1;
        unique case (op_code)
            bsfu_pkg::flag_set_generic_op:     flag_val = 1'b1;
            bsfu_pkg::flag_clear_generic_op:   flag_val = 1'b0;
            bsfu_pkg::bit_to_transfer_flag_op: begin
                flag_idx = `BSFU_FLAG_T;
                flag_val = source_register[op_bit];
            end
            bsfu_pkg::carry_set_op:            flag_idx = `BSFU_FLAG_C;
            bsfu_pkg::carry_clear_op: begin
                flag_idx = `BSFU_FLAG_C;
                flag_val = 1'b0;
            end
            bsfu_pkg::irq_enable_op:           flag_idx = `BSFU_FLAG_I;
            bsfu_pkg::irq_disable_op: begin
                flag_idx = `BSFU_FLAG_I;
                flag_val = 1'b0;
            end
            bsfu_pkg::signed_flag_set_op:      flag_idx = `BSFU_FLAG_S;
            bsfu_pkg::signed_flag_clear_op: begin
                flag_idx = `BSFU_FLAG_S;
                flag_val = 1'b0;
            end
            bsfu_pkg::overflow_set_op:         flag_idx = `BSFU_FLAG_V;
            bsfu_pkg::overflow_clear_op: begin
                flag_idx = `BSFU_FLAG_V;
                flag_val = 1'b0;
            end
            bsfu_pkg::negative_set_op:         flag_idx = `BSFU_FLAG_N;
            bsfu_pkg::negative_clear_op: begin
                flag_idx = `BSFU_FLAG_N;
                flag_val = 1'b0;
            end
            bsfu_pkg::zero_flag_set_op:        flag_idx = `BSFU_FLAG_Z;
            bsfu_pkg::zero_flag_clear_op: begin
                flag_idx = `BSFU_FLAG_Z;
                flag_val = 1'b0;
            end
            bsfu_pkg::transfer_flag_set_op:    flag_idx = `BSFU_FLAG_T;
            bsfu_pkg::transfer_flag_clear_op: begin
                flag_idx = `BSFU_FLAG_T;
                flag_val = 1'b0;
            end
            default:                           flag_wr  = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // datapath pieces
    // ------------------------------------------------------------
    bsfu_shifter u_shifter (
        .op_code      (op_code),
        .data_in      (dst_data),
        .carry_in     (status_register_ff[`BSFU_FLAG_C]),
        .result       (sh_result),
        .carry_out    (sh_c),
        .zero_out     (sh_z),
        .negative_out (sh_n),
        .overflow_out (sh_v)
    );

    bsfu_bit_put #(.W(8)) u_flag_put (
        .data_in  (status_register_ff),
        .index    (flag_idx),
        .value    (flag_val),
        .data_out (flag_result)
    );

    bsfu_bit_put #(.W(8)) u_bld_put (
        .data_in  (dst_data),
        .index    (op_bit),
        .value    (status_register_ff[`BSFU_FLAG_T]),
        .data_out (bld_result)
    );

    bsfu_bit_put #(.W(8)) u_io_put (
        .data_in  (io_rd_data),
        .index    (io_bit_ff),
        .value    (io_set_ff),
        .data_out (io_result)
    );

    // ------------------------------------------------------------
    // io read-modify-write sequencer
    // ------------------------------------------------------------
    // the io space answers io_rd_data in the cycle io_rd_en_ff is high;
    // the decoder is held off for that cycle via op_ready_ff
    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff    <= bsfu_pkg::st_idle;
            op_ready_ff <= 1'b1;
            io_rd_en_ff <= 1'b0;
            io_wr_en_ff <= 1'b0;
            io_addr_ff  <= 6'h00;
            io_set_ff   <= 1'b0;
            io_bit_ff   <= 3'h0;
        end else begin
            io_rd_en_ff <= 1'b0;
            io_wr_en_ff <= 1'b0;
            unique case (state_ff)
                bsfu_pkg::st_idle: begin
                    if (accept && (op_code == bsfu_pkg::io_bit_clear_op ||
                                   op_code == bsfu_pkg::io_bit_set_op)) begin
                        state_ff    <= bsfu_pkg::st_io_read;
                        op_ready_ff <= 1'b0;
                        io_rd_en_ff <= 1'b1;
                        io_addr_ff  <= op_io_addr;
                        io_set_ff   <= (op_code == bsfu_pkg::io_bit_set_op);
                        io_bit_ff   <= op_bit;
                    end
                end
                bsfu_pkg::st_io_read: begin
                    state_ff    <= bsfu_pkg::st_idle;
                    op_ready_ff <= 1'b1;
                    io_wr_en_ff <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            io_wr_data_ff <= 8'h00;
        end else if (state_ff == bsfu_pkg::st_io_read) begin
            io_wr_data_ff <= io_result;
        end
    end

    // ------------------------------------------------------------
    // working register write back
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            rf_wr_en_ff   <= 1'b0;
            rf_wr_data_ff <= 8'h00;
        end else begin
            rf_wr_en_ff <= 1'b0;
            if (accept && is_shift) begin
                rf_wr_en_ff   <= 1'b1;
                rf_wr_data_ff <= sh_result;
            end else if (accept && op_code == bsfu_pkg::nibble_swap_op) begin
                rf_wr_en_ff   <= 1'b1;
                rf_wr_data_ff <= {dst_data[3:0], dst_data[7:4]};
            end else if (accept && op_code == bsfu_pkg::transfer_flag_to_bit_op) begin
                rf_wr_en_ff   <= 1'b1;
                rf_wr_data_ff <= bld_result;
            end
        end
    end

    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            status_register_ff <= `BSFU_STATUS_RESET;
        end else if (accept && is_shift) begin
            status_register_ff[`BSFU_FLAG_C] <= sh_c;
            status_register_ff[`BSFU_FLAG_Z] <= sh_z;
            status_register_ff[`BSFU_FLAG_N] <= sh_n;
            status_register_ff[`BSFU_FLAG_V] <= sh_v;
        end else if (accept && flag_wr) begin
            status_register_ff <= flag_result;
        end
    end

    // completion strobe: one cycle after a single-cycle op, or the io write
    always_ff @(posedge clock) begin
        if (reset) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= (accept && state_ff == bsfu_pkg::st_idle &&
                        op_code != bsfu_pkg::io_bit_clear_op &&
                        op_code != bsfu_pkg::io_bit_set_op) ||
                       state_ff == bsfu_pkg::st_io_read;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    io_clear_bit_a: assert property (accept && op_code == bsfu_pkg::io_bit_clear_op |->
        ##2 io_wr_en_ff && done_ff && status_register_ff == $past(status_register_ff, 2)
        && io_wr_data_ff == ($past(io_rd_data) & ~(8'h01 << $past(op_bit, 2))))
        else $error("io bit clear wrong");
    io_set_bit_a: assert property (accept && op_code == bsfu_pkg::io_bit_set_op |->
        ##1 io_rd_en_ff && !op_ready_ff ##1 io_wr_en_ff && done_ff
        && io_wr_data_ff == ($past(io_rd_data) | (8'h01 << $past(op_bit, 2))))
        else $error("io bit set wrong");
    left_shift_a: assert property (accept && op_code == bsfu_pkg::logical_left_shift_op |=>
        rf_wr_en_ff && rf_wr_data_ff == {$past(dst_data[6:0]), 1'b0}
        && status_register_ff[0] == $past(dst_data[7]) && status_register_ff[2] == rf_wr_data_ff[7])
        else $error("logical left shift wrong");
    right_shift_a: assert property (accept && op_code == bsfu_pkg::logical_right_shift_op |=>
        rf_wr_data_ff == {1'b0, $past(dst_data[7:1])} && status_register_ff[0] == $past(dst_data[0])
        && status_register_ff[1] == (rf_wr_data_ff == 8'h00))
        else $error("logical right shift wrong");
    rot_left_a: assert property (accept && op_code == bsfu_pkg::rotate_left_carry_op |=>
        rf_wr_data_ff == {$past(dst_data[6:0]), $past(status_register_ff[0])}
        && status_register_ff[0] == $past(dst_data[7]))
        else $error("rotate left wrong");
    rot_right_a: assert property (accept && op_code == bsfu_pkg::rotate_right_carry_op |=>
        rf_wr_data_ff == {$past(status_register_ff[0]), $past(dst_data[7:1])}
        && status_register_ff[0] == $past(dst_data[0]))
        else $error("rotate right wrong");
    arith_shift_a: assert property (accept && op_code == bsfu_pkg::arith_right_shift_op |=>
        rf_wr_en_ff && rf_wr_data_ff == {$past(dst_data[7]), $past(dst_data[7:1])}
        && status_register_ff[0] == $past(dst_data[0])
        && status_register_ff[3] == (status_register_ff[2] ^ status_register_ff[0]))
        else $error("arithmetic shift wrong");
    nibble_swap_a: assert property (accept && op_code == bsfu_pkg::nibble_swap_op |=>
        rf_wr_data_ff == {$past(dst_data[3:0]), $past(dst_data[7:4])} && $stable(status_register_ff))
        else $error("nibble swap wrong");
    generic_flag_a: assert property (accept && op_code == bsfu_pkg::flag_clear_generic_op |=>
        status_register_ff == ($past(status_register_ff) & ~(8'h01 << $past(op_bit))))
        else $error("generic flag clear wrong");
    bit_store_a: assert property (accept && op_code == bsfu_pkg::bit_to_transfer_flag_op |=>
        status_register_ff[6] == $past(source_register[op_bit])
        && status_register_ff[5:0] == $past(status_register_ff[5:0]) && !rf_wr_en_ff)
        else $error("bit store wrong");
    bit_load_a: assert property (accept && op_code == bsfu_pkg::transfer_flag_to_bit_op |=>
        rf_wr_en_ff && rf_wr_data_ff[$past(op_bit)] == status_register_ff[6]
        && $stable(status_register_ff))
        else $error("bit load wrong");
    carry_ops_a: assert property (accept && op_code == bsfu_pkg::carry_clear_op |=>
        status_register_ff == ($past(status_register_ff) & 8'hfe))
        else $error("carry clear wrong");
    irq_ops_a: assert property (accept && op_code == bsfu_pkg::irq_enable_op |=>
        status_register_ff == ($past(status_register_ff) | 8'h80))
        else $error("irq enable wrong");
    signed_ops_a: assert property (accept && op_code == bsfu_pkg::signed_flag_set_op |=>
        status_register_ff == ($past(status_register_ff) | 8'h10))
        else $error("signed flag set wrong");
    overflow_ops_a: assert property (accept && op_code == bsfu_pkg::overflow_clear_op |=>
        status_register_ff == ($past(status_register_ff) & 8'hf7))
        else $error("overflow clear wrong");
    zero_ops_a: assert property (accept && op_code == bsfu_pkg::zero_flag_set_op |=>
        status_register_ff == ($past(status_register_ff) | 8'h02) && done_ff)
        else $error("zero flag set wrong");

    io_seq_c: cover property (accept && op_code == bsfu_pkg::io_bit_set_op ##2 io_wr_en_ff);
    rotate_c: cover property (accept && op_code == bsfu_pkg::rotate_left_carry_op
        ##1 status_register_ff[0]);
    back_c:   cover property (accept ##1 accept ##1 accept);
    flag_c:   cover property (accept && op_code == bsfu_pkg::flag_set_generic_op);

endmodule // bsfu_top

`default_nettype wire

// ===== tb/bsfu_io_model.sv
// io space model that answers the unit's reads and takes its write backs
`timescale 1ns/10ps
`default_nettype none

module bsfu_io_model (
    // clock
    input  wire logic       clock,
    // io strobes from the unit
    input  wire logic       io_rd_en_ff,
    input  wire logic       io_wr_en_ff,
    input  wire logic [5:0] io_addr_ff,
    input  wire logic [7:0] io_wr_data_ff,
    // read answer
    output logic      [7:0] io_rd_data
);
    logic [7:0] mem [64];
    logic [7:0] last_ff = 8'h00;
    initial for (int i = 0; i < 64; i++) mem[i] = 8'(i * 8'h5b + 8'h3c);
    // answer within the read cycle; outside it drive the inverse so a late sample is caught
    always_comb io_rd_data = io_rd_en_ff ? mem[io_addr_ff] : ~last_ff;
    always @(posedge clock) begin
        if (io_rd_en_ff) last_ff <= mem[io_addr_ff];
        if (io_wr_en_ff) mem[io_addr_ff] <= io_wr_data_ff;
    end
endmodule // bsfu_io_model

`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench of the bit, shift and flag unit
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    // ----------------------------------------------------------------
    // stimulus, design and io model
    // ----------------------------------------------------------------
    logic               clock = 1'b0;
    logic               reset = 1'b1;
    logic               op_valid = 1'b0;
    bsfu_pkg::bsfu_op_t op_code = bsfu_pkg::io_bit_clear_op;
    logic [2:0]         op_bit = 3'h0;
    logic [5:0]         op_io_addr = 6'h00;
    logic [7:0]         dst_data = 8'h00, source_register = 8'h00;
    logic               op_ready_ff, done_ff, rf_wr_en_ff, io_rd_en_ff, io_wr_en_ff;
    logic [7:0]         rf_wr_data_ff, io_wr_data_ff, io_rd_data, status_register_ff;
    logic [5:0]         io_addr_ff;
    logic [7:0]         exp_sr = 8'h00;
    int                 err_total = 0;
    int                 compares = 0;
    integer             seed = 71;
    always #12.5 clock = ~clock;
    bsfu_top bsfu_top_i (.clock, .reset, .op_valid, .op_code, .op_bit, .op_io_addr, .dst_data,
        .source_register, .op_ready_ff, .done_ff, .rf_wr_en_ff, .rf_wr_data_ff, .io_rd_en_ff,
        .io_wr_en_ff, .io_addr_ff, .io_wr_data_ff, .io_rd_data, .status_register_ff);
    bsfu_io_model bsfu_io_model_i (.clock, .io_rd_en_ff, .io_wr_en_ff, .io_addr_ff,
        .io_wr_data_ff, .io_rd_data);

    // ----------------------------------------------------------------
    // expectation: {write back, result or io byte, status}
    // ----------------------------------------------------------------
    function automatic logic [16:0] model(input logic [4:0] op, input logic [7:0] d, s, io,
                                          input logic [2:0] b, input logic [7:0] sr_in);
        logic [7:0] r, sr;
        logic       c, w;
        logic [20:0] idx;
        idx = 21'h18a738; // flag index per dedicated set/clear pair: c i s v n z t
        r = d; sr = sr_in; c = sr_in[0]; w = 1'b1;
        case (op)
            5'h00: begin r = io; r[b] = 1'b0; w = 1'b0; end
            5'h01: begin r = io; r[b] = 1'b1; w = 1'b0; end
            5'h02: {c, r} = {d, 1'b0};
            5'h03: {r, c} = {1'b0, d};
            5'h04: {c, r} = {d, sr_in[0]};
            5'h05: {r, c} = {sr_in[0], d};
            5'h06: {r, c} = {d[7], d};
            5'h07: r = {d[3:0], d[7:4]};
            5'h08: begin sr[b] = 1'b1; w = 1'b0; end
            5'h09: begin sr[b] = 1'b0; w = 1'b0; end
            5'h0a: begin sr[6] = s[b]; w = 1'b0; end
            5'h0b: r[b] = sr_in[6];
            default: begin sr[idx[3*((op-5'h0c)>>1) +: 3]] = ~op[0]; w = 1'b0; end
        endcase
        if (op >= 5'h02 && op <= 5'h06) sr[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
        return {w, r, sr};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // drives one op at a falling edge, keeps valid high so ops run back to back
    task automatic run_op(input logic [4:0] op, input logic [7:0] d, s,
                          input logic [2:0] b, input logic [5:0] a);
        logic [16:0] e;
        int          n;
        logic [1:0]  mid;
        op_valid = 1'b1; op_code = bsfu_pkg::bsfu_op_t'(op); dst_data = d;
        source_register = s; op_bit = b; op_io_addr = a;
        n = 0;
        mid = 2'h0;
        // for an io op the first cycle shows the io read strobe and the held-off decoder
        do begin
            @(negedge clock);
            n++;
            if (n == 1) mid = {io_rd_en_ff, op_ready_ff};
        end while (done_ff !== 1'b1 && n < 4);
        e = model(op, d, s, bsfu_io_model_i.mem[a], b, exp_sr);
        check(8'(n), (op < 5'h02) ? 8'h02 : 8'h01, "latency");
        check(status_register_ff, e[7:0], "status");
        check({6'h00, rf_wr_en_ff, io_wr_en_ff}, {6'h00, e[16], op < 5'h02}, "strobes");
        check({6'h00, mid}, {6'h00, op < 5'h02, op >= 5'h02}, "read step");
        if (e[16]) check(rf_wr_data_ff, e[15:8], "result");
        if (op < 5'h02) check(io_wr_data_ff, e[15:8], "io byte");
        if (op < 5'h02) check({2'b00, io_addr_ff}, {2'b00, a}, "io address");
        exp_sr = e[7:0];
    endtask

    // reset with the decoder idle, then the status and the strobes at their reset levels
    task automatic do_reset(input int cycles);
        op_valid = 1'b0;
        reset = 1'b1;
        repeat (cycles) @(negedge clock);
        reset = 1'b0;
        exp_sr = 8'h00;
        @(negedge clock);
        check(status_register_ff, 8'h00, "reset status");
        check({3'h0, op_ready_ff, done_ff, rf_wr_en_ff, io_rd_en_ff, io_wr_en_ff}, 8'h10,
              "reset strobes");
        $display("reset test done, mismatches %0d", err_total);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        do_reset(8);
        // every op once, with edge values that expose carry and sign handling
        for (int k = 0; k < 26; k++) run_op(5'(k), 8'h81, 8'h40, 3'(k), 6'(k));
        $display("directed ops done, mismatches %0d", err_total);
        for (int k = 0; k < 400; k++) run_op(5'($unsigned($random(seed)) % 26), 8'($random(seed)),
            8'($random(seed)), 3'($random(seed)), 6'($random(seed)));
        $display("random ops done, mismatches %0d", err_total);
        // reset in mid-run with flags set, then every op again from a clean status
        do_reset(2);
        for (int k = 0; k < 26; k++) run_op(5'(k), 8'h7e, 8'hbf, 3'(k + 3), 6'(63 - k));
        op_valid = 1'b0;
        $display("directed ops after reset done, mismatches %0d", err_total);
        finish_test;
    end
    initial begin
        #(25 * 5000);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test;
    end
endmodule // tb_top

`default_nettype wire
